// [verilog/programmable_logic_array.sv]
// Decode array, general logic array, output router and register slave
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - Eight main sector selects, three terms each
// - Four secondary sector selects, three terms each
// - One memory select from two terms
// - Register block select from one term
// - Two external selects, one term each
// - Two peripheral range selects, one term
// - Term ANDs inputs; outputs OR their terms
// - Sixteen output cells, twenty-two input pins, 137 terms
// - XOR stage sets each cell polarity
// - Multiplexer picks stored or bypassed result
// - Result reaches pin, read path, feedback together
// - Storage element acts as D, T, JK, SR
// - Clock, preset, clear each from own term
// - Preset and clear are active-high levels
// - Storage captures on rising selected clock
// - Common clock pin may replace term clock
// - Each cell drives one chosen pin, or none
// - First bank: three native, borrow six
// - Second bank cells 0-3: four, borrow five
// - Second bank cells 4-7: four, borrow six
// - Borrow only unused terms, no extra stage
// - Processor load overrides preset, clear, clock
// - Mask bit one blocks processor load
// - Array content fixed, processor cannot change it
module programmable_logic_array #(
	parameter int ADDR_W = 10,
	parameter bit LARGE_PACKAGE = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Processor bus signals
	input wire logic [logic_array_pkg::CPU_ADDR_W-1:0] cpu_address,
	input wire logic cpu_psen,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic cpu_ale,
	input wire logic mcu_reset,
	input wire logic power_down,
	input wire logic [logic_array_pkg::PAGE_W-1:0] page,
	input wire logic ready_busy,
	// Port pins in
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	input wire logic [3:0] port_c_in,
	input wire logic [1:0] port_d_in,
	// Fixed array content
	input wire logic [logic_array_pkg::DECODE_TERMS*logic_array_pkg::BUS_INPUTS-1:0] decode_true_mask,
	input wire logic [logic_array_pkg::DECODE_TERMS*logic_array_pkg::BUS_INPUTS-1:0] decode_comp_mask,
	input wire logic [logic_array_pkg::GLA_TERMS*logic_array_pkg::BUS_INPUTS-1:0] gla_true_mask,
	input wire logic [logic_array_pkg::GLA_TERMS*logic_array_pkg::BUS_INPUTS-1:0] gla_comp_mask,
	input wire logic [logic_array_pkg::CELLS-1:0] cell_used,
	input wire logic [logic_array_pkg::CELLS-1:0] cell_invert,
	input wire logic [logic_array_pkg::CELLS-1:0] cell_bypass,
	input wire logic [logic_array_pkg::CELLS-1:0] cell_common_clock,
	input wire logic [2*logic_array_pkg::CELLS-1:0] cell_ff_type,
	input wire logic [logic_array_pkg::CELLS*logic_array_pkg::BORROW_WINDOW-1:0] cell_borrow_mask,
	input wire logic [logic_array_pkg::CELLS-1:0] cell_route_en,
	input wire logic [logic_array_pkg::CELLS-1:0] cell_route_upper,
	// Decode selects
	output logic [logic_array_pkg::MAIN_SELECTS-1:0] main_sector_selects,
	output logic [logic_array_pkg::SEC_SELECTS-1:0] secondary_sector_selects,
	output logic sram_select,
	output logic csr_block_select,
	output logic [logic_array_pkg::EXT_SELECTS-1:0] external_selects,
	output logic peripheral_range_select_0,
	output logic peripheral_range_select_1,
	// Port pins out
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe,
	output logic [7:0] port_c_out,
	output logic [7:0] port_c_oe
);
	import logic_array_pkg::*;

	localparam int PIN_W = 22;

	function automatic int nat_base(input int c);
		return (c < BANK) ? NATIVE_AB * c : NATIVE_AB * BANK + NATIVE_BC * (c - BANK);
	endfunction

	logic [PIN_W-1:0] pin_meta_q;
	logic [PIN_W-1:0] pin_sync_q;
	logic [BUS_INPUTS-1:0] bus_in;
	logic [DECODE_TERMS-1:0] dec_terms;
	logic [GLA_TERMS-1:0] gla_terms;
	logic [CELLS-1:0] cell_result;
	logic [CELLS-1:0] cell_out_q;
	logic [CELLS-1:0] cell_load;
	logic [7:0] mask_ab_q;
	logic [7:0] mask_bc_q;
	logic aw_have_q;
	logic w_have_q;
	logic [REG_INDEX_W-1:0] aw_idx_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic commit;
	logic wr_mapped;
	logic [REG_INDEX_W-1:0] ar_idx;
	logic [7:0] rd_value;
	logic rd_mapped;

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the common clock pin is the first port D pin

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= {port_d_in, port_c_in, port_b_in, port_a_in};
			pin_sync_q <= pin_meta_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Shared input bus; feedback is the registered cell result

	assign bus_in[IN_ADDR +: CPU_ADDR_W] = cpu_address;
	assign bus_in[IN_PSEN] = cpu_psen;
	assign bus_in[IN_RD] = cpu_rd;
	assign bus_in[IN_WR] = cpu_wr;
	assign bus_in[IN_ALE] = cpu_ale;
	assign bus_in[IN_RESET] = mcu_reset;
	assign bus_in[IN_PDN] = power_down;
	assign bus_in[IN_PA +: 8] = LARGE_PACKAGE ? pin_sync_q[7:0] : 8'h00;
	assign bus_in[IN_PB +: 8] = pin_sync_q[15:8];
	assign bus_in[IN_PC +: 4] = pin_sync_q[19:16];
	assign bus_in[IN_PD +: 2] = pin_sync_q[21:20];
	assign bus_in[IN_PAGE +: PAGE_W] = page;
	assign bus_in[IN_FB_AB +: BANK] = cell_out_q[BANK-1:0];
	assign bus_in[IN_FB_BC +: BANK] = cell_out_q[CELLS-1:BANK];
	assign bus_in[IN_READY] = ready_busy;

	//////////////////////////////////////////////////////////////////////////
	// Decode array; content arrives only on fixed ports

	product_term_array #(
		.TERMS(DECODE_TERMS),
		.INPUTS(BUS_INPUTS)
	) u_decode_array (
		.inputs(bus_in),
		.true_mask(decode_true_mask),
		.comp_mask(decode_comp_mask),
		.terms(dec_terms)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_sector_selects <= '0;
			secondary_sector_selects <= '0;
			sram_select <= 1'b0;
			csr_block_select <= 1'b0;
			external_selects <= '0;
			peripheral_range_select_0 <= 1'b0;
			peripheral_range_select_1 <= 1'b0;
		end else begin
			for (int i = 0; i < MAIN_SELECTS; i++) begin
				main_sector_selects[i] <= |dec_terms[DEC_MAIN_BASE + MAIN_TERMS*i +: MAIN_TERMS];
			end
			for (int i = 0; i < SEC_SELECTS; i++) begin
				secondary_sector_selects[i] <= |dec_terms[DEC_SEC_BASE + SEC_TERMS*i +: SEC_TERMS];
			end
			sram_select <= |dec_terms[DEC_SRAM_BASE +: SRAM_TERMS];
			csr_block_select <= dec_terms[DEC_CSR];
			// Small package has one port D select pin only
			external_selects[0] <= dec_terms[DEC_EXT_BASE];
			external_selects[1] <= dec_terms[DEC_EXT_BASE + 1] & LARGE_PACKAGE;
			peripheral_range_select_0 <= dec_terms[DEC_PERIPH_BASE];
			peripheral_range_select_1 <= dec_terms[DEC_PERIPH_BASE + 1];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// General logic array terms and cells

	product_term_array #(
		.TERMS(GLA_TERMS),
		.INPUTS(BUS_INPUTS)
	) u_general_logic_array (
		.inputs(bus_in),
		.true_mask(gla_true_mask),
		.comp_mask(gla_comp_mask),
		.terms(gla_terms)
	);

	// Borrowing is a wider OR, so it costs no extra stage
	for (genvar k = 0; k < CELLS; k++) begin : g_cell
		localparam int POS = k % BANK;
		localparam int BASE = k - POS;
		localparam int NAT = (k < BANK) ? NATIVE_AB : NATIVE_BC;
		localparam int LIMIT = (k < BANK) ? BORROW_AB : ((POS < 4) ? BORROW_BC_LOW : BORROW_BC_HIGH);
		localparam int PREV = BASE + (POS + BANK - 1) % BANK;
		localparam int NEXT = BASE + (POS + 1) % BANK;
		localparam logic [BORROW_WINDOW-1:0] LIMIT_MASK = BORROW_WINDOW'((1 << LIMIT) - 1);
		localparam int CTRL = CTRL_BASE + CTRL_PER_CELL * k;
		logic [BORROW_WINDOW-1:0] window;
		logic sum;

		always_comb begin
			window = '0;
			for (int j = 0; j < NAT; j++) begin
				window[j] = gla_terms[nat_base(PREV) + j] & ~cell_used[PREV];
				window[NAT + j] = gla_terms[nat_base(NEXT) + j] & ~cell_used[NEXT];
			end
		end

		assign sum = (|gla_terms[nat_base(k) +: NAT]) |
			(|(window & LIMIT_MASK & cell_borrow_mask[k*BORROW_WINDOW +: BORROW_WINDOW]));

		output_macrocell u_cell (
			.aclk(aclk),
			.aresetn(aresetn),
			.sum(sum),
			.aux_term(gla_terms[CTRL + CTRL_AUX]),
			.clk_term(gla_terms[CTRL + CTRL_CLK]),
			.preset_term(gla_terms[CTRL + CTRL_PRESET]),
			.clear_term(gla_terms[CTRL + CTRL_CLEAR]),
			.common_clock(pin_sync_q[20]),
			.ff_type(ff_type_t'(cell_ff_type[2*k +: 2])),
			.invert(cell_invert[k]),
			.bypass(cell_bypass[k]),
			.use_common_clock(cell_common_clock[k]),
			.load(cell_load[k]),
			.load_data(wbyte_q[POS]),
			.result(cell_result[k])
		);
	end

	//////////////////////////////////////////////////////////////////////////
	// Result register and output router

	// One register feeds read data and feedback; the pins have their own register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cell_out_q <= '0;
		end else begin
			cell_out_q <= cell_result;
		end
	end

	// A first-bank cell wins port B if both banks claim a pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_out <= '0;
			port_a_oe <= '0;
			port_b_out <= '0;
			port_b_oe <= '0;
			port_c_out <= '0;
			port_c_oe <= '0;
		end else begin
			for (int i = 0; i < BANK; i++) begin
				port_a_out[i] <= cell_result[i];
				port_a_oe[i] <= cell_route_en[i] & ~cell_route_upper[i] & LARGE_PACKAGE;
				port_b_out[i] <= (cell_route_en[i] & cell_route_upper[i]) ? cell_result[i] : cell_result[BANK+i];
				port_b_oe[i] <= (cell_route_en[i] & cell_route_upper[i]) |
					(cell_route_en[BANK+i] & ~cell_route_upper[BANK+i]);
				port_c_out[i] <= cell_result[BANK+i];
				port_c_oe[i] <= cell_route_en[BANK+i] & cell_route_upper[BANK+i] & PORT_C_ROUTABLE[i];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Register slave, write side

	assign commit = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign wr_mapped = (aw_idx_q == IDX_CELLS_AB) | (aw_idx_q == IDX_CELLS_BC) |
		(aw_idx_q == IDX_MASK_AB) | (aw_idx_q == IDX_MASK_BC);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_have_q <= 1'b0;
			aw_idx_q <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_have_q <= 1'b1;
			aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
		end else if (commit) begin
			aw_have_q <= 1'b0;
		end else if (!aw_have_q & !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_have_q <= 1'b0;
			wbyte_q <= '0;
			wlane_q <= 1'b0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_have_q <= 1'b1;
			wbyte_q <= s_axi_wdata[7:0];
			wlane_q <= s_axi_wstrb[0];
		end else if (commit) begin
			w_have_q <= 1'b0;
		end else if (!w_have_q & !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (commit) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Only cell loads and masks are writable; array content is not
	always_comb begin
		for (int i = 0; i < BANK; i++) begin
			cell_load[i] = commit & wlane_q & (aw_idx_q == IDX_CELLS_AB) & ~mask_ab_q[i];
			cell_load[BANK+i] = commit & wlane_q & (aw_idx_q == IDX_CELLS_BC) & ~mask_bc_q[i];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_ab_q <= MASK_RESET;
			mask_bc_q <= MASK_RESET;
		end else if (commit & wlane_q) begin
			if (aw_idx_q == IDX_MASK_AB) begin
				mask_ab_q <= wbyte_q;
			end
			if (aw_idx_q == IDX_MASK_BC) begin
				mask_bc_q <= wbyte_q;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Register slave, read side

	assign ar_idx = s_axi_araddr[ADDR_W-1:2];

	always_comb begin
		rd_mapped = 1'b1;
		unique case (ar_idx)
			IDX_CELLS_AB: rd_value = cell_out_q[BANK-1:0];
			IDX_CELLS_BC: rd_value = cell_out_q[CELLS-1:BANK];
			IDX_MASK_AB: rd_value = mask_ab_q;
			IDX_MASK_BC: rd_value = mask_bc_q;
			default: begin
				rd_value = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_value};
			s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// [verilog/logic_array_pkg.sv]
// Shared constants and types for the programmable decode and logic array
package logic_array_pkg;
	// Shared input bus of the two arrays
	localparam int BUS_INPUTS = 69;
	localparam int CPU_ADDR_W = 16;
	localparam int PAGE_W = 8;
	localparam int IN_ADDR = 0;
	localparam int IN_PSEN = 16;
	localparam int IN_RD = 17;
	localparam int IN_WR = 18;
	localparam int IN_ALE = 19;
	localparam int IN_RESET = 20;
	localparam int IN_PDN = 21;
	localparam int IN_PA = 22;
	localparam int IN_PB = 30;
	localparam int IN_PC = 38;
	localparam int IN_PD = 42;
	localparam int IN_PAGE = 44;
	localparam int IN_FB_AB = 52;
	localparam int IN_FB_BC = 60;
	localparam int IN_READY = 68;
	//////////////////////////////////////////////////////////////////////////
	// Decode array term layout
	localparam int MAIN_SELECTS = 8;
	localparam int MAIN_TERMS = 3;
	localparam int SEC_SELECTS = 4;
	localparam int SEC_TERMS = 3;
	localparam int SRAM_TERMS = 2;
	localparam int EXT_SELECTS = 2;
	localparam int DEC_MAIN_BASE = 0;
	localparam int DEC_SEC_BASE = 24;
	localparam int DEC_SRAM_BASE = 36;
	localparam int DEC_CSR = 38;
	localparam int DEC_EXT_BASE = 39;
	localparam int DEC_PERIPH_BASE = 41;
	localparam int DECODE_TERMS = 43;
	//////////////////////////////////////////////////////////////////////////
	// General logic array layout; the array offers up to 137 terms
	localparam int GLA_TERM_CAPACITY = 137;
	localparam int CELLS = 16;
	localparam int BANK = 8;
	localparam int NATIVE_AB = 3;
	localparam int NATIVE_BC = 4;
	localparam int BORROW_AB = 6;
	localparam int BORROW_BC_LOW = 5;
	localparam int BORROW_BC_HIGH = 6;
	localparam int BORROW_WINDOW = 8;
	localparam int CTRL_BASE = 56;
	localparam int CTRL_PER_CELL = 4;
	localparam int CTRL_CLK = 0;
	localparam int CTRL_PRESET = 1;
	localparam int CTRL_CLEAR = 2;
	localparam int CTRL_AUX = 3;
	localparam int GLA_TERMS = 120;
	localparam logic [7:0] PORT_C_ROUTABLE = 8'h9C;
	localparam logic CELL_RESET = 1'b0;
	//////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam int REG_INDEX_W = 8;
	localparam logic [7:0] IDX_CELLS_AB = 8'h20;
	localparam logic [7:0] IDX_CELLS_BC = 8'h21;
	localparam logic [7:0] IDX_MASK_AB = 8'h22;
	localparam logic [7:0] IDX_MASK_BC = 8'h23;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_type_t;
endpackage

// [verilog/product_term_array.sv]
// Bank of product terms, each an AND of chosen true or inverted inputs
`timescale 1ns/100ps
module product_term_array #(
	parameter int TERMS = 1,
	parameter int INPUTS = 69
) (
	// Shared inputs
	input wire logic [INPUTS-1:0] inputs,
	// Fixed term content
	input wire logic [TERMS*INPUTS-1:0] true_mask,
	input wire logic [TERMS*INPUTS-1:0] comp_mask,
	// Term results
	output logic [TERMS-1:0] terms
);
	import logic_array_pkg::*;

	// An empty term reads false so unused terms never fire
	for (genvar t = 0; t < TERMS; t++) begin : g_term
		logic [INPUTS-1:0] tm;
		logic [INPUTS-1:0] cm;
		assign tm = true_mask[t*INPUTS +: INPUTS];
		assign cm = comp_mask[t*INPUTS +: INPUTS];
		assign terms[t] = (|(tm | cm)) & (&(~tm | inputs)) & (&(~cm | ~inputs));
	end
endmodule

// [verilog/output_macrocell.sv]
// One output macrocell: polarity, storage element and bypass
`timescale 1ns/100ps
module output_macrocell (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Array terms and common clock pin
	input wire logic sum,
	input wire logic aux_term,
	input wire logic clk_term,
	input wire logic preset_term,
	input wire logic clear_term,
	input wire logic common_clock,
	// Fixed configuration
	input wire logic_array_pkg::ff_type_t ff_type,
	input wire logic invert,
	input wire logic bypass,
	input wire logic use_common_clock,
	// Processor load
	input wire logic load,
	input wire logic load_data,
	// Result
	output logic result
);
	import logic_array_pkg::*;

	logic d_in;
	logic clk_sel;
	logic clk_prev_q;
	logic rise;
	logic next_d;
	logic state_q;

	assign d_in = sum ^ invert;
	assign clk_sel = use_common_clock ? common_clock : clk_term;
	assign rise = clk_sel & ~clk_prev_q;

	always_comb begin
		unique case (ff_type)
			FF_D: next_d = d_in;
			FF_T: next_d = state_q ^ d_in;
			FF_JK: next_d = (d_in & ~state_q) | (~aux_term & state_q);
			FF_SR: next_d = d_in | (~aux_term & state_q);
		endcase
	end

	// Runs through reset: no false edge on release
	always_ff @(posedge aclk) begin
		clk_prev_q <= clk_sel;
	end

	// Load beats preset and clear, which beat the clock edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= CELL_RESET;
		end else if (load) begin
			state_q <= load_data;
		end else if (preset_term) begin
			state_q <= 1'b1;
		end else if (clear_term) begin
			state_q <= 1'b0;
		end else if (rise) begin
			state_q <= next_d;
		end
	end

	assign result = bypass ? d_in : state_q;
endmodule

// [verification/pla_chk.sv]
// Checker of register bus timing and pin enables of the array
`timescale 1ns/100ps
module pla_chk
	import logic_array_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pin enables
	input wire logic [7:0] port_b_oe,
	input wire logic [7:0] port_c_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	//////////////////////////////////////////////////////////////////////////
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Only the four cell and mask words are mapped
	sequence s_rd_unmapped;
		s_rd_taken ##0 (s_axi_araddr[9:2] < 8'h20 || s_axi_araddr[9:2] > 8'h23);
	endsequence
	//////////////////////////////////////////////////////////////////////////
	a_write_answer: assert property (s_wr_taken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after request");
	a_ready_drops: assert property (s_wr_taken |=> (!s_axi_awready && !s_axi_wready) [*2])
		else $error("write readies did not drop after request");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read data not one cycle after request");
	a_unmapped_read: assert property (s_rd_unmapped |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped while stalled");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while stalled");
	a_read_high: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_portc_pins: assert property ((port_c_oe & ~PORT_C_ROUTABLE) == 8'h00)
		else $error("cell drives a port C pin that is not routable");
	a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && port_b_oe == 8'h00)
		else $error("outputs active right after reset");
endmodule
bind programmable_logic_array pla_chk pla_chk_inst (.*);

// [verification/cpu_bus_model.sv]
// Processor bus and pin driver facing the array inputs
`timescale 1ns/100ps
module cpu_bus_model (
	// Clock and control
	input wire logic aclk,
	input wire logic step,
	// Processor bus
	output logic [15:0] cpu_address,
	output logic cpu_rd,
	output logic cpu_wr,
	output logic cpu_ale,
	output logic mcu_reset,
	output logic power_down,
	output logic [7:0] page,
	output logic ready_busy,
	// Port pins
	output logic [7:0] port_a_in,
	output logic [7:0] port_b_in,
	output logic [3:0] port_c_in,
	output logic [1:0] port_d_in
);
	// Values change only on request so the bench can hold inputs steady
	initial begin
		{cpu_address, cpu_rd, cpu_wr, cpu_ale, mcu_reset, power_down, page, ready_busy} = '0;
		{port_a_in, port_b_in, port_c_in, port_d_in} = '0;
	end
	always @(posedge aclk) begin
		if (step) begin
			{cpu_address, cpu_rd, cpu_wr, cpu_ale, mcu_reset, power_down} <= 21'($urandom);
			{page, ready_busy, port_a_in, port_b_in, port_c_in, port_d_in} <= 31'($urandom);
		end
	end
endmodule

// [verification/programmable_logic_array_test.sv]
// Self-checking bench of the decode and logic array
`timescale 1ns/100ps
module programmable_logic_array_test;
	import logic_array_pkg::*;
	localparam int DI = DECODE_TERMS*BUS_INPUTS;
	localparam int GI = GLA_TERMS*BUS_INPUTS;
	logic aclk, aresetn, step, cpu_psen;
	logic [9:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] cpu_address;
	logic cpu_rd, cpu_wr, cpu_ale, mcu_reset, power_down, ready_busy;
	logic [7:0] page, port_a_in, port_b_in;
	logic [3:0] port_c_in;
	logic [1:0] port_d_in;
	logic [DI-1:0] decode_true_mask, decode_comp_mask;
	logic [GI-1:0] gla_true_mask, gla_comp_mask;
	logic [15:0] cell_used, cell_invert, cell_bypass, cell_common_clock, cell_route_en, cell_route_upper;
	logic [31:0] cell_ff_type;
	logic [127:0] cell_borrow_mask;
	logic [7:0] main_sector_selects, port_a_out, port_a_oe, port_b_out, port_b_oe, port_c_out, port_c_oe;
	logic [3:0] secondary_sector_selects;
	logic [1:0] external_selects;
	logic sram_select, csr_block_select, peripheral_range_select_0, peripheral_range_select_1;
	int num_errors, n_tests;
	//////////////////////////////////////////////////////////////////////////
	programmable_logic_array programmable_logic_array_inst (.*);
	cpu_bus_model cpu_bus_model_inst (.*);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	//////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("Counts: %0d mismatches in %0d comparisons", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// Decode term t tests one address bit, inverted on odd t
	function automatic logic dterm(int t);
		return (t % 2 == 0) ? cpu_address[(t*5)%16] : !cpu_address[(t*5)%16];
	endfunction
	// Response ready is raised one cycle late so the stall path is exercised
	task axi_wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 50);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
		if (n >= 50) begin
			num_errors++;
			complete_run;
		end
	endtask
	task axi_rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 50);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		resp = s_axi_rresp;
		if (n >= 50) begin
			num_errors++;
			complete_run;
		end
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, step, cpu_psen, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{decode_true_mask, decode_comp_mask, gla_true_mask, gla_comp_mask} = '0;
		{cell_used, cell_invert, cell_bypass, cell_common_clock, cell_route_en, cell_route_upper} = '0;
		cell_ff_type = '0;
		cell_borrow_mask = '0;
		num_errors = 0;
		n_tests = 0;
		for (int t = 0; t < DECODE_TERMS; t++) begin
			decode_true_mask[t*BUS_INPUTS+(t*5)%16] = (t % 2 == 0);
			decode_comp_mask[t*BUS_INPUTS+(t*5)%16] = (t % 2 == 1);
		end
		// Cell 8 inverts address bit 3 straight to port B pin 0; cell 1 presets from the strobe
		gla_true_mask[24*BUS_INPUTS+IN_ADDR+3] = 1'b1;
		gla_true_mask[61*BUS_INPUTS+IN_PSEN] = 1'b1;
		{cell_used[8], cell_invert[8], cell_bypass[8], cell_route_en[8]} = 4'hF;
		void'($urandom(35912));
		repeat (6) @(posedge aclk);
		@(negedge aclk);
		chk(main_sector_selects, 32'h0);
		chk(port_b_oe, 32'h0);
		@(posedge aclk) aresetn <= 1'b1;
		repeat (20) begin
			@(posedge aclk) step <= 1'b1;
			@(posedge aclk) step <= 1'b0;
			repeat (2) @(posedge aclk);
			@(negedge aclk);
			for (int i = 0; i < MAIN_SELECTS; i++)
				chk(main_sector_selects[i], dterm(3*i) | dterm(3*i+1) | dterm(3*i+2));
			for (int i = 0; i < SEC_SELECTS; i++)
				chk(secondary_sector_selects[i], dterm(24+3*i) | dterm(25+3*i) | dterm(26+3*i));
			chk(sram_select, dterm(36) | dterm(37));
			chk(csr_block_select, dterm(38));
			chk(external_selects, {dterm(40), dterm(39)});
			chk({peripheral_range_select_1, peripheral_range_select_0}, {dterm(42), dterm(41)});
			chk(port_b_out[0], !cpu_address[3]);
			chk({port_a_out, port_c_out}, {15'h0, !cpu_address[3]});
			chk({port_a_oe, port_b_oe, port_c_oe}, 32'h000100);
		end
		$display("Decode and bypass test done");
		@(posedge aclk);
		axi_rd(10'h088, d, r);
		chk(d, MASK_RESET);
		axi_wr(10'h088, 32'h0000000F, r);
		chk(r, RESP_OKAY);
		cpu_psen <= 1'b1;
		repeat (4) @(posedge aclk);
		cpu_psen <= 1'b0;
		repeat (4) @(posedge aclk);
		axi_wr(10'h080, 32'h000000FF, r);
		axi_rd(10'h080, d, r);
		chk(d, 32'h000000F2);
		axi_wr(10'h088, 32'h00000000, r);
		axi_wr(10'h080, 32'h00000000, r);
		axi_rd(10'h080, d, r);
		chk(d, 32'h00000000);
		axi_rd(10'h084, d, r);
		chk(d, {31'h0, !cpu_address[3]});
		axi_rd(10'h3FC, d, r);
		chk(d, 32'h0);
		chk(r, RESP_DECERR);
		axi_wr(10'h3FC, 32'hFFFFFFFF, r);
		chk(r, RESP_DECERR);
		@(negedge aclk);
		chk(port_b_out[0], !cpu_address[3]);
		$display("Register test done");
		complete_run;
	end
endmodule
